// [hdl/ext_status_pkg.sv]
// Constants for the extender status register bank.
// Assumes one 50 MHz clock and synchronous inputs from the bridge core.
// Overview of operation
// - Read-only status at offset 20h, 16/8-bit
// - Bit 15 always reads zero
// - Bit 14 mirrors comparison mode control bit
// - Bit 13 reads one whenever the upper lane is enabled
// - Bit 12 set after posted write error
// - Posted error kept per side, independently
// - Each copy set by its forwarded posted errors
// - Copy clears on own-side upper-lane read, any reset
// - Bit 11 timeout flag, upper-lane read or reset clears
// - Bit 3 high while self-setup runs
// - Bit 2 bus error flag, success clears
// - Bit 0 parity flag, clean transfer clears
package ext_status_pkg;
  localparam logic [7:0] STATUS_OFFSET = 8'h20;
  localparam int RSVD15_POS = 15;
  localparam int MODE_MIRROR_POS = 14;
  localparam int RSVD13_POS = 13;
  localparam int POST_ERR_POS = 12;
  localparam int TIMEOUT_POS = 11;
  localparam int INTERLOCK_POS = 10;
  localparam int DFAIL_POS = 9;
  localparam int FAIR_POS = 8;
  localparam int CTRL_POS = 7;
  localparam int SETUP_POS = 3;
  localparam int BERR_POS = 2;
  localparam int PARITY_POS = 0;
  localparam logic RSVD15_VAL = 1'b0;
  localparam logic RSVD13_VAL = 1'b1;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam int UPPER_LANE = 1;
  localparam int LOWER_LANE = 0;
endpackage

// [hdl/extender_status_register.sv]
// Status register of the backplane to cable extender, readable from both buses.
// Assumes the bridge core presents one-cycle event pulses and steady levels,
// all synchronous to mclk; rst is the hard reset, soft_reset the soft one.
`timescale 1ns/1ns
module extender_status_register
  import ext_status_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic vxi_rd,
  input wire logic [7:0] vxi_addr,
  input wire logic [1:0] vxi_be,
  output logic vxi_ack,
  output logic [15:0] vxi_rdata,
  input wire logic cable_rd,
  input wire logic [7:0] cable_addr,
  input wire logic [1:0] cable_be,
  output logic cable_ack,
  output logic [15:0] cable_rdata,
  input wire logic comparison_mode,
  input wire logic interlocked,
  input wire logic drive_failure_line,
  input wire logic fair_requester,
  input wire logic cable_controller,
  input wire logic self_setup_busy,
  input wire logic vxi_post_err,
  input wire logic cable_post_err,
  input wire logic controller_timeout,
  input wire logic cable_berr_driven,
  input wire logic cable_access_ok,
  input wire logic cable_xfer_done,
  input wire logic cable_xfer_parity_bad
);

  logic vxi_post_reg, vxi_post_next;
  logic cable_post_reg, cable_post_next;
  logic timeout_reg, timeout_next;
  logic berr_reg, berr_next;
  logic parity_reg, parity_next;
  logic vxi_ack_reg, vxi_ack_next, cable_ack_reg, cable_ack_next;
  logic [15:0] vxi_data_reg, vxi_data_next, cable_data_reg, cable_data_next;
  logic vxi_hit, cable_hit;

  // Assemble the status word as seen from one side
  function automatic logic [15:0] status_word(input logic post_bit, input logic [1:0] be);
    logic [15:0] w;
    w = 16'h0000;
    w[RSVD15_POS] = RSVD15_VAL;
    w[MODE_MIRROR_POS] = comparison_mode;
    w[RSVD13_POS] = RSVD13_VAL;
    w[POST_ERR_POS] = post_bit;
    w[TIMEOUT_POS] = timeout_reg;
    w[INTERLOCK_POS] = interlocked;
    w[DFAIL_POS] = drive_failure_line;
    w[FAIR_POS] = fair_requester;
    w[CTRL_POS] = cable_controller;
    w[SETUP_POS] = self_setup_busy;
    w[BERR_POS] = berr_reg;
    w[PARITY_POS] = parity_reg;
    // Lanes not enabled read zero, so a byte access sees only its byte
    if (!be[UPPER_LANE]) begin
      w[15:8] = 8'h00;
    end
    if (!be[LOWER_LANE]) begin
      w[7:0] = 8'h00;
    end
    return w;
  endfunction

  // decode of the single read-only offset
  assign vxi_hit = vxi_rd && (vxi_addr == STATUS_OFFSET);
  assign cable_hit = cable_rd && (cable_addr == STATUS_OFFSET);

  // Flag next values; a set beats a read or success clear in the same cycle so no event is lost; soft reset beats every set
  always_comb begin
    // two copies; each set by its own side
    // read clears only the reading side's copy (upper lane carries it)
    vxi_post_next = vxi_post_reg;
    if (vxi_hit && vxi_be[UPPER_LANE]) begin
      vxi_post_next = 1'b0;
    end
    if (vxi_post_err) begin
      vxi_post_next = 1'b1;
    end
    cable_post_next = cable_post_reg;
    if (cable_hit && cable_be[UPPER_LANE]) begin
      cable_post_next = 1'b0;
    end
    if (cable_post_err) begin
      cable_post_next = 1'b1;
    end
    // timeout flag, cleared by an upper-lane read from either side
    timeout_next = timeout_reg;
    if ((vxi_hit && vxi_be[UPPER_LANE]) || (cable_hit && cable_be[UPPER_LANE])) begin
      timeout_next = 1'b0;
    end
    if (controller_timeout && cable_controller) begin
      timeout_next = 1'b1;
    end
    berr_next = berr_reg;
    if (cable_access_ok) begin
      berr_next = 1'b0;
    end
    if (cable_berr_driven) begin
      berr_next = 1'b1;
    end
    parity_next = parity_reg;
    if (cable_xfer_done) begin
      parity_next = cable_xfer_parity_bad;
    end
    // soft reset clears every event flag
    if (soft_reset) begin
      vxi_post_next = FLAG_RESET;
      cable_post_next = FLAG_RESET;
      timeout_next = FLAG_RESET;
      berr_next = FLAG_RESET;
      parity_next = FLAG_RESET;
    end
  end

  // Read answers: snapshot taken before the read-clear lands
  always_comb begin
    vxi_ack_next = vxi_rd;
    cable_ack_next = cable_rd;
    // Unmapped offsets still answer, with zero data, so no master hangs
    vxi_data_next = DATA_RESET;
    cable_data_next = DATA_RESET;
    // each side reads its own posted copy only
    if (vxi_hit) begin
      vxi_data_next = status_word(vxi_post_reg, vxi_be);
    end
    if (cable_hit) begin
      cable_data_next = status_word(cable_post_reg, cable_be);
    end
  end

  // Registers; hard reset clears all flags and answers
  always_ff @(posedge mclk) begin
    if (rst) begin
      vxi_post_reg <= FLAG_RESET;
      cable_post_reg <= FLAG_RESET;
      timeout_reg <= FLAG_RESET;
      berr_reg <= FLAG_RESET;
      parity_reg <= FLAG_RESET;
      vxi_ack_reg <= 1'b0;
      cable_ack_reg <= 1'b0;
      vxi_data_reg <= DATA_RESET;
      cable_data_reg <= DATA_RESET;
    end else begin
      vxi_post_reg <= vxi_post_next;
      cable_post_reg <= cable_post_next;
      timeout_reg <= timeout_next;
      berr_reg <= berr_next;
      parity_reg <= parity_next;
      vxi_ack_reg <= vxi_ack_next;
      cable_ack_reg <= cable_ack_next;
      vxi_data_reg <= vxi_data_next;
      cable_data_reg <= cable_data_next;
    end
  end

  assign vxi_ack = vxi_ack_reg;
  assign vxi_rdata = vxi_data_reg;
  assign cable_ack = cable_ack_reg;
  assign cable_rdata = cable_data_reg;

  // Checks
  sequence s_vxi_full_read;
    vxi_hit && (vxi_be == 2'b11);
  endsequence

  sequence s_cable_full_read;
    cable_hit && (cable_be == 2'b11);
  endsequence

  property p_rsvd_bits;
    @(posedge mclk) disable iff (rst)
    s_vxi_full_read |=> vxi_ack && !vxi_rdata[RSVD15_POS] && vxi_rdata[RSVD13_POS];
  endproperty
  a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bits wrong");

  property p_mode_mirror;
    @(posedge mclk) disable iff (rst)
    s_cable_full_read |=> cable_rdata[MODE_MIRROR_POS] == $past(comparison_mode);
  endproperty
  a_mode_mirror: assert property (p_mode_mirror) else $error("mode mirror wrong");

  // Idle cycle between two steps; nothing may set or clear the backplane copy
  sequence s_vxi_quiet;
    !vxi_hit && !soft_reset && !vxi_post_err;
  endsequence

  sequence s_vxi_post_event;
    vxi_post_err && !soft_reset;
  endsequence

  property p_post_set;
    @(posedge mclk) disable iff (rst || soft_reset)
    s_vxi_post_event ##1 s_vxi_quiet ##1 s_vxi_full_read |=> vxi_rdata[POST_ERR_POS];
  endproperty
  a_post_set: assert property (p_post_set) else $error("posted error not seen");

  property p_post_clear;
    @(posedge mclk) disable iff (rst)
    s_vxi_full_read ##0 (!vxi_post_err && !soft_reset) ##1 s_vxi_quiet ##1 s_vxi_full_read
      |=> !vxi_rdata[POST_ERR_POS];
  endproperty
  a_post_clear: assert property (p_post_clear) else $error("read did not clear");

  // A cable read of the upper lane in the same cycle may clear its own copy
  property p_sides_apart;
    @(posedge mclk) disable iff (rst)
    (vxi_hit && cable_post_reg && !soft_reset && !(cable_hit && cable_be[UPPER_LANE]))
      |=> cable_post_reg;
  endproperty
  a_sides_apart: assert property (p_sides_apart) else $error("other copy disturbed");

  property p_timeout;
    @(posedge mclk) disable iff (rst)
    (controller_timeout && cable_controller && !soft_reset) |=> timeout_reg;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag missed");

  property p_setup;
    @(posedge mclk) disable iff (rst)
    s_cable_full_read |=> cable_rdata[SETUP_POS] == $past(self_setup_busy);
  endproperty
  a_setup: assert property (p_setup) else $error("setup bit wrong");

  property p_berr;
    @(posedge mclk) disable iff (rst)
    (cable_access_ok && !cable_berr_driven) |=> !berr_reg;
  endproperty
  a_berr: assert property (p_berr) else $error("bus error not cleared");

  property p_parity;
    @(posedge mclk) disable iff (rst)
    (cable_xfer_done && !soft_reset) |=> parity_reg == $past(cable_xfer_parity_bad);
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");

  property p_soft;
    @(posedge mclk) disable iff (rst)
    soft_reset |=> !vxi_post_reg && !cable_post_reg && !timeout_reg && !berr_reg && !parity_reg;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left a flag");

  property p_offset;
    @(posedge mclk) disable iff (rst)
    (vxi_rd && vxi_addr != STATUS_OFFSET) |=> vxi_ack && vxi_rdata == 16'h0000;
  endproperty
  a_offset: assert property (p_offset) else $error("unmapped read not zero");

endmodule

// [sim/read_master.sv]
// Bus master model that issues one-cycle read strobes to a status port.
// Assumes the bench times req on mclk; address and lanes scramble when idle.
`timescale 1ns/1ns
module read_master (
  input wire logic req,
  input wire logic [7:0] req_addr,
  input wire logic [1:0] req_be,
  output logic rd,
  output logic [7:0] addr,
  output logic [1:0] be
);
  // An idle master shows the inverse, so a stale address never looks valid
  assign rd = req;
  assign addr = req ? req_addr : ~req_addr;
  assign be = req ? req_be : ~req_be;
endmodule

// [sim/extender_status_register_bench.sv]
// Self-checking bench for the extender status register, with a flag model.
// Assumes one read_master model in front of each read port.
`timescale 1ns/1ns
module extender_status_register_bench;
  import ext_status_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, soft_reset = 1'b0, vreq = 1'b0, creq = 1'b0;
  logic [7:0] raddr = 8'h00;
  logic [1:0] rbe = 2'h0;
  logic [5:0] lv = 6'h00;
  logic [6:0] ev = 7'h00;
  logic vxi_rd, cable_rd, vxi_ack, cable_ack;
  logic [7:0] vxi_addr, cable_addr;
  logic [1:0] vxi_be, cable_be;
  logic [15:0] vxi_rdata, cable_rdata;
  int err_count = 0, total_checks = 0, cycles = 0, pv, pc, tmo, berr, par, i;
  read_master vm (.req(vreq), .req_addr(raddr), .req_be(rbe), .rd(vxi_rd), .addr(vxi_addr),
    .be(vxi_be));
  read_master cm (.req(creq), .req_addr(raddr), .req_be(rbe), .rd(cable_rd),
    .addr(cable_addr), .be(cable_be));
  extender_status_register dut (.mclk(mclk), .rst(rst), .soft_reset(soft_reset),
    .vxi_rd(vxi_rd), .vxi_addr(vxi_addr), .vxi_be(vxi_be), .vxi_ack(vxi_ack),
    .vxi_rdata(vxi_rdata), .cable_rd(cable_rd), .cable_addr(cable_addr),
    .cable_be(cable_be), .cable_ack(cable_ack), .cable_rdata(cable_rdata),
    .comparison_mode(lv[0]), .interlocked(lv[1]), .drive_failure_line(lv[2]),
    .fair_requester(lv[3]), .cable_controller(lv[4]), .self_setup_busy(lv[5]),
    .vxi_post_err(ev[0]), .cable_post_err(ev[1]), .controller_timeout(ev[2]),
    .cable_berr_driven(ev[3]), .cable_access_ok(ev[4]), .cable_xfer_done(ev[5]),
    .cable_xfer_parity_bad(ev[6]));
  // Clock and hang guard; a run needs well under 3000 cycles
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: word %h, model %h", $time, got, exp);
    end
  endtask
  task chk_ack(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: ack %b, model %b", $time, got, exp);
    end
  endtask
  // Model word from live levels and flags; unselected lanes and offsets read 0
  function automatic logic [15:0] word(input int pe, input logic [1:0] b, input logic [7:0] a);
    logic [15:0] w;
    w = {1'b0, lv[0], 1'b1, pe[0], tmo[0], lv[1], lv[2], lv[3], lv[4], 3'h0, lv[5],
      berr[0], 1'b0, par[0]};
    if (a != 8'h20) w = 16'h0000;
    return w & {{8{b[1]}}, {8{b[0]}}};
  endfunction
  task clr();
    pv = 0; pc = 0; tmo = 0; berr = 0; par = 0;
  endtask
  // Events for one cycle; soft reset beats every set, bus error beats success
  task step(input logic [7:0] e);
    @(posedge mclk);
    ev <= e[6:0];
    soft_reset <= e[7];
    @(posedge mclk);
    ev <= 7'h00;
    soft_reset <= 1'b0;
    if (e[7]) clr();
    else begin
      pv = pv | e[0];
      pc = pc | e[1];
      if (e[2] && lv[4]) tmo = 1;
      if (e[3]) berr = 1;
      else if (e[4]) berr = 0;
      if (e[5]) par = e[6];
    end
  endtask
  // One read on either or both ports, with fresh random levels
  task rd(input logic v, input logic c, input logic [7:0] a, input logic [1:0] b);
    @(posedge mclk);
    vreq <= v; creq <= c; raddr <= a; rbe <= b; lv <= 6'($urandom);
    @(posedge mclk);
    vreq <= 1'b0; creq <= 1'b0;
    #1;
    chk_ack(vxi_ack, v);
    chk_ack(cable_ack, c);
    if (v) chk_word(vxi_rdata, word(pv, b, a));
    if (c) chk_word(cable_rdata, word(pc, b, a));
    if (a == 8'h20 && b[1]) begin
      if (v) pv = 0;
      if (c) pc = 0;
      if (v || c) tmo = 0;
    end
  endtask
  task hard_reset(input int n);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (n) @(posedge mclk);
    rst <= 1'b0;
    clr();
  endtask
  task test_done();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    i = $urandom(16);
    hard_reset(16);
    rd(1'b1, 1'b1, 8'h20, 2'h3);
    $display("test reset values done");
    // Each side sees only its own posted error, cleared by its own full read
    for (i = 0; i < 2; i++) begin
      step(8'h01 << i);
      rd(i == 1, i == 0, 8'h20, 2'h3);
      rd(1'b1, 1'b1, 8'h22, 2'h3);
      rd(1'b1, 1'b1, 8'h20, 2'h1);
      rd(1'b1, 1'b1, 8'h20, 2'h3);
      rd(1'b1, 1'b1, 8'h20, 2'h3);
      $display("test posted side %0d done", i);
    end
    step(8'h0F);
    step(8'h8F);
    rd(1'b1, 1'b1, 8'h20, 2'h3);
    $display("test soft reset done");
    for (i = 0; i < 300; i++) begin
      step({$urandom_range(7) == 0, 7'($urandom)});
      rd(1'($urandom), 1'($urandom), $urandom_range(1) ? 8'h20 : 8'h1E, 2'($urandom));
    end
    $display("test random traffic done");
    hard_reset(2);
    rd(1'b1, 1'b1, 8'h20, 2'h3);
    $display("test hard reset done");
    test_done();
  end
endmodule
